// ---- dv/borc_supply_model.sv ----
// Behavioural analog supply monitor for the bench.
// Assumes the bench commands levels; outputs move at clock edges.
module borc_supply_model (
  input wire logic clk_in,
  input wire logic ready_cmd_in,
  input wire logic low_cmd_in,
  output logic circuit_ready_out,
  output logic supply_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    circuit_ready_out = 1'b0;
    supply_low_out = 1'b0;
  end
  always @(posedge clk_in) begin
    circuit_ready_out <= ready_cmd_in;
    supply_low_out <= low_cmd_in;
  end
endmodule : borc_supply_model

// ---- dv/borc_top_test.sv ----
// Self-checking bench for the brown-out reset control block.
// Assumes a short power-up delay parameter of 8 cycles.
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); \
  end \
end
module borc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [1:0] mode = 2'h0;
  logic sw = 1'b0;
  logic pte = 1'b1;
  logic sleep = 1'b0;
  logic rdy_cmd = 1'b0;
  logic low_cmd = 1'b0;
  logic rdy;
  logic low;
  logic flag;
  logic active;
  logic rst_out;
  int num_errors = 0;
  int compares = 0;
  int n;
  borc_supply_model borc_supply_model_inst (.clk_in(clk_in),
    .ready_cmd_in(rdy_cmd), .low_cmd_in(low_cmd),
    .circuit_ready_out(rdy), .supply_low_out(low));
  borc_top #(.PWRT_CYCLES(8)) borc_top_inst (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .brownout_mode_cfg_in(mode),
    .sw_brownout_enable_in(sw), .powerup_timer_enable_in(pte),
    .sleep_in(sleep), .circuit_ready_in(rdy), .supply_low_in(low),
    .brownout_ready_flag_out(flag), .protect_active_out(active),
    .brownout_reset_out(rst_out));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic drive(input logic [1:0] m, input logic s, p, r, l);
    @(posedge clk_in);
    mode <= m;
    sw <= s;
    pte <= p;
    rdy_cmd <= r;
    low_cmd <= l;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : drive
  task automatic t_off;
    for (int m = 0; m < 4; m++) begin
      if (m == 1) continue;
      drive(m[1:0], 1'b1, 1'b1, 1'b1, 1'b1);
      `CHK("off_active", 1'b0, active)
      `CHK("off_reset", 1'b0, rst_out)
      `CHK("off_flag", 1'b1, flag)
    end
    drive(2'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    $display("test off done");
  endtask : t_off
  task automatic t_ready;
    drive(2'h1, 1'b1, 1'b1, 1'b0, 1'b1);
    `CHK("nrdy_flag", 1'b0, flag)
    `CHK("nrdy_reset", 1'b0, rst_out)
    drive(2'h1, 1'b1, 1'b1, 1'b1, 1'b0);
    `CHK("rdy_flag", 1'b1, flag)
    `CHK("rdy_active", 1'b1, active)
    $display("test ready done");
  endtask : t_ready
  task automatic t_sw;
    drive(2'h1, 1'b0, 1'b1, 1'b1, 1'b1);
    `CHK("sw_off_active", 1'b0, active)
    `CHK("sw_off_reset", 1'b0, rst_out)
    drive(2'h1, 1'b1, 1'b1, 1'b1, 1'b0);
    `CHK("sw_on_active", 1'b1, active)
    @(posedge clk_in);
    sleep <= 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("sleep_active", 1'b1, active)
    @(posedge clk_in);
    sleep <= 1'b0;
    $display("test sw done");
  endtask : t_sw
  task automatic t_trip(input logic p);
    drive(2'h1, 1'b1, p, 1'b1, 1'b1);
    `CHK("trip_reset", 1'b1, rst_out)
    @(posedge clk_in);
    low_cmd <= 1'b0;
    n = 0;
    while (rst_out === 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    `CHK("trip_end", 1'b0, rst_out)
    `CHK("trip_hold", 1'b1, p ? n <= 7 : n >= 9)
    $display("test trip %0d done, hold %0d", p, n);
  endtask : t_trip
  task automatic end_sim;
    $display("comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_off();
    t_ready();
    t_sw();
    t_trip(1'b1);
    t_trip(1'b0);
    end_sim();
  end
  initial begin
    // Tests take under 150 cycles; the 2000-cycle limit leaves wide margin on top
    #20us;
    num_errors++;
    end_sim();
  end
endmodule : borc_top_test

// ---- pkg/bor_ctl_pkg.sv ----
// Package for the brown-out reset control block.
// Assumes a single 100 MHz clock and no register bus.
package bor_ctl_pkg;

  // ----------------------------------------------------------------
  // Mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Power-up delay in microseconds; plain default, no figure given
  localparam int unsigned PWRT_DELAY_US = 64;
  localparam int unsigned PWRT_CYCLES =
    (PWRT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BORC_IDLE,
    BORC_TRIP,
    BORC_DELAY
  } borc_state_t;

  typedef struct packed {
    borc_state_t state;
    logic [CNT_W-1:0] cnt;
    logic trip_s1;
    logic trip_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic reset;
    logic ready;
    logic active;
  } borc_regs_t;

endpackage : bor_ctl_pkg

// ---- src/borc_delay_cnt.sv ----
// Down counter that times the power-up delay.
// Assumes the caller loads it and watches done.
module borc_delay_cnt #(
  parameter int unsigned W = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);
  logic [W-1:0] cnt_ff;
  logic done_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
      done_ff <= 1'b1;
    end else if (load_in) begin
      cnt_ff <= value_in;
      done_ff <= (value_in == '0);
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
      done_ff <= (cnt_ff == {{(W-1){1'b0}}, 1'b1});
    end
  end

  assign done_out = done_ff;
endmodule : borc_delay_cnt

// ---- src/borc_top.sv ----
// Brown-out reset control: mode select, ready flag, reset and delay.
// Assumes trip and ready inputs synchronous-clean levels from analog.
//
// Notes on behaviour
// - Mode 00 keeps protection off always
// - Start-up never waits for circuit ready
// - Mode 01 follows the software enable bit
// - Act on trips only once circuit ready
// - Ready flag mirrors circuit readiness, read-only
// - Sleep leaves protection state unchanged
// - Add power-up delay only when enable is 0
module borc_top #(
  parameter int unsigned PWRT_CYCLES = bor_ctl_pkg::PWRT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] brownout_mode_cfg_in,
  input wire logic sw_brownout_enable_in,
  input wire logic powerup_timer_enable_in,
  input wire logic sleep_in,
  input wire logic circuit_ready_in,
  input wire logic supply_low_in,
  output logic brownout_ready_flag_out,
  output logic protect_active_out,
  output logic brownout_reset_out
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bor_ctl_pkg::borc_regs_t regs_ff;
  bor_ctl_pkg::borc_regs_t nxt_regs;
  logic enabled;
  logic dly_load;
  logic dly_done;

  // Sleep is deliberately not an input of this decode
  assign enabled = (brownout_mode_cfg_in == bor_ctl_pkg::MODE_SW) &&
                   sw_brownout_enable_in;

  borc_delay_cnt #(
    .W(bor_ctl_pkg::CNT_W)
  ) u_dly (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .load_in(dly_load),
    .value_in(bor_ctl_pkg::CNT_W'(PWRT_CYCLES)),
    .done_out(dly_done)
  );

  always_comb begin
    nxt_regs = regs_ff;
    dly_load = 1'b0;
    nxt_regs.trip_s1 = supply_low_in;
    nxt_regs.trip_s2 = regs_ff.trip_s1;
    nxt_regs.rdy_s1 = circuit_ready_in;
    nxt_regs.rdy_s2 = regs_ff.rdy_s1;
    nxt_regs.ready = regs_ff.rdy_s2;
    // Protection arms on the third clock after the circuit is ready
    nxt_regs.active = enabled && regs_ff.rdy_s2;
    unique case (regs_ff.state)
      bor_ctl_pkg::BORC_IDLE: begin
        if (regs_ff.active && regs_ff.trip_s2) begin
          nxt_regs.state = bor_ctl_pkg::BORC_TRIP;
        end
      end
      bor_ctl_pkg::BORC_TRIP: begin
        if (!regs_ff.trip_s2 || !regs_ff.active) begin
          if (!powerup_timer_enable_in) begin
            nxt_regs.state = bor_ctl_pkg::BORC_DELAY;
            dly_load = 1'b1;
          end else begin
            nxt_regs.state = bor_ctl_pkg::BORC_IDLE;
          end
        end
      end
      bor_ctl_pkg::BORC_DELAY: begin
        // A new trip during the delay restarts the reset
        if (regs_ff.active && regs_ff.trip_s2) begin
          nxt_regs.state = bor_ctl_pkg::BORC_TRIP;
        end else if (dly_done) begin
          nxt_regs.state = bor_ctl_pkg::BORC_IDLE;
        end
      end
      default: nxt_regs.state = bor_ctl_pkg::BORC_IDLE;
    endcase
    // No wait on readiness out of reset: idle means reset released
    nxt_regs.reset = (nxt_regs.state != bor_ctl_pkg::BORC_IDLE);
    nxt_regs.cnt = bor_ctl_pkg::CNT_RST;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      regs_ff <= '{state: bor_ctl_pkg::BORC_IDLE,
                   cnt: bor_ctl_pkg::CNT_RST, default: 1'b0};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign brownout_ready_flag_out = regs_ff.ready;
  assign protect_active_out = regs_ff.active;
  assign brownout_reset_out = regs_ff.reset;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  mode_off_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (brownout_mode_cfg_in == bor_ctl_pkg::MODE_OFF) ##1
    (brownout_mode_cfg_in == bor_ctl_pkg::MODE_OFF) |-> !protect_active_out)
    else $error("protection active in off mode");
  no_startup_wait_a: assert property (@(posedge clk_in)
    $rose(rst_n) |-> !brownout_reset_out [*3])
    else $error("start-up held by brown-out logic");
  sw_enable_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (enabled && regs_ff.rdy_s2) |=> protect_active_out)
    else $error("software enable not followed");
  ready_gate_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    protect_active_out |-> $past(regs_ff.rdy_s2))
    else $error("protection active before ready");
  ready_flag_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    circuit_ready_in ##1 circuit_ready_in ##1 circuit_ready_in
    |=> brownout_ready_flag_out)
    else $error("ready flag missed readiness");
  sleep_keep_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    ($changed(sleep_in) && $stable(enabled) && $stable(regs_ff.rdy_s2)
     && $past(protect_active_out) == (enabled && regs_ff.rdy_s2))
    |=> $stable(protect_active_out))
    else $error("sleep changed protection");
  no_delay_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (regs_ff.state == bor_ctl_pkg::BORC_TRIP && !regs_ff.trip_s2 &&
     powerup_timer_enable_in) |=> !brownout_reset_out)
    else $error("delay added with timer off");
  pwrt_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (regs_ff.state == bor_ctl_pkg::BORC_TRIP && !regs_ff.trip_s2 &&
     !powerup_timer_enable_in) |=> brownout_reset_out)
    else $error("power-up delay skipped");
  trip_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n)
    (regs_ff.active && regs_ff.trip_s2) |=> brownout_reset_out)
    else $error("trip did not reset");
  trip_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    $rose(brownout_reset_out));
  delay_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    regs_ff.state == bor_ctl_pkg::BORC_DELAY ##1
    regs_ff.state == bor_ctl_pkg::BORC_IDLE);
  ready_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    $rose(protect_active_out));
endmodule : borc_top
